// file: logic/cwc_ctrl.sv
// Charger wire cleaner controller: pass scheduling, motor sequencing,
// Wishbone register slave.
// Assumes synchronous inputs, active-low limit switches, and a motor
// driver that decodes the two drive lines.
//
// How it works
// R01: A pass is requested out of every reset, which is power-on.
// R02: Leaving energy saving requests a pass.
// R03: Closing the front cover after it was open requests a pass.
// R04: Pages since the last pass are counted and a pass is due at the threshold.
// R05: A pass due by page count waits while a print job is active.
// R06: Outside a pass the cleaner is driven to and kept at home.
// R07: Reverse rotation carries the cleaner toward the far end.
// R08: Normal rotation carries the cleaner back toward home.
// R09: The far switch going low turns the motor to normal rotation.
// R10: Drive code {a,b} is off 00, reverse 01, normal 10, brake 11.
// R11: The home sense line is low only with the cleaner at home.
// R12: The far sense line is low only with the cleaner at the far end.
// R13: A pass starts in reverse and holds it until the far line is low.
// R14: Home low on return brakes, then stops, and clears the page count.
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "cwc_defines.svh"

module cwc_ctrl
  import cwc_pkg::*;
#(
  parameter logic [`CWC_BRAKE_W-1:0] BRAKE_CYCLES =
    `CWC_BRAKE_W'(`CWC_BRAKE_CYCLES),
  parameter logic [`CWC_STROKE_W-1:0] STROKE_CYCLES =
    `CWC_STROKE_W'(`CWC_STROKE_CYCLES)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire cwc_wb_req_s wb_req_i,
  output cwc_wb_rsp_s wb_rsp_o,
  input wire logic energy_save_i,
  input wire logic front_cover_open_i,
  input wire logic page_printed_i,
  input wire logic job_active_i,
  input wire logic home_pos_sense_n_i,
  input wire logic far_pos_sense_n_i,
  output logic cleaner_drive_a_o,
  output logic cleaner_drive_b_o,
  output logic pass_busy_o
);

  localparam cwc_ctrl_state_s CWC_RST = '{
    st: CWC_IDLE,
    pass: 1'b0,
    fault: 1'b0,
    evt_pend: 1'b1, // R01
    energy_q: 1'b0,
    cover_q: 1'b0,
    enable: `CWC_EN_RST,
    ack: 1'b0,
    rdata: 32'h0000_0000,
    cnt: 16'h0000,
    thresh: `CWC_THRESH_RST,
    drive: `CWC_DRV_OFF
  };

  cwc_ctrl_state_s cur;
  cwc_ctrl_state_s next_cur;

  logic brake_done;
  logic stroke_done;
  logic brake_load;
  logic stroke_load;
  logic acc;
  logic wr;
  logic start_wr;
  logic fclr_wr;
  logic energy_ret;
  logic cover_close;
  logic page_req;
  logic launch;
  logic pass_done;
  logic stroke_abort;

  // ****************************************************************
  // Timers
  // ****************************************************************
  cwc_down_timer #(
    .W(`CWC_BRAKE_W)
  ) u_brake_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(brake_load),
    .load_val_i(BRAKE_CYCLES),
    .done_o(brake_done)
  );

  // Guards against a stalled motor or a dead switch
  cwc_down_timer #(
    .W(`CWC_STROKE_W)
  ) u_stroke_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(stroke_load),
    .load_val_i(STROKE_CYCLES),
    .done_o(stroke_done)
  );

  assign brake_load = (cur.st != CWC_BRAKE) && (next_cur.st == CWC_BRAKE);
  assign stroke_load = (next_cur.st != cur.st) &&
    ((next_cur.st == CWC_REV) || (next_cur.st == CWC_FWD));

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_cur = cur;
    acc = wb_req_i.cyc && wb_req_i.stb && !cur.ack;
    wr = acc && wb_req_i.we;
    start_wr = wr && (wb_req_i.adr == `CWC_ADR_CTRL) && wb_req_i.sel[0] &&
      wb_req_i.dat[`CWC_CTRL_START_BIT];
    fclr_wr = wr && (wb_req_i.adr == `CWC_ADR_CTRL) && wb_req_i.sel[0] &&
      wb_req_i.dat[`CWC_CTRL_FCLR_BIT];
    energy_ret = cur.energy_q && !energy_save_i; // R02
    cover_close = cur.cover_q && !front_cover_open_i; // R03
    // Zero threshold turns page-driven passes off
    page_req = (cur.thresh != 16'h0000) && (cur.cnt >= cur.thresh); // R04
    launch = (cur.st == CWC_IDLE) && cur.enable && !cur.fault &&
      (cur.evt_pend || (page_req && !job_active_i)); // R05
    pass_done = (cur.st == CWC_BRAKE) && brake_done && cur.pass;
    stroke_abort = ((cur.st == CWC_REV) || (cur.st == CWC_FWD)) &&
      stroke_done;

    next_cur.energy_q = energy_save_i;
    next_cur.cover_q = front_cover_open_i;
    // Set wins over the clear taken by a launch
    next_cur.evt_pend = (cur.evt_pend && !launch) || energy_ret ||
      cover_close || start_wr;
    next_cur.fault = (cur.fault && !fclr_wr) || stroke_abort;

    // Page arriving in the clearing cycle still counts
    if (pass_done) begin
      next_cur.cnt = 16'h0000; // R14
    end
    if (page_printed_i && (next_cur.cnt != 16'hffff)) begin
      next_cur.cnt = next_cur.cnt + 16'h0001; // R04
    end

    case (cur.st)
      CWC_IDLE: begin
        if (launch) begin
          next_cur.st = CWC_REV; // R13
          next_cur.pass = 1'b1;
        end else if (home_pos_sense_n_i) begin
          next_cur.st = CWC_FWD; // R06
          next_cur.pass = 1'b0;
        end
      end
      CWC_REV: begin
        if (stroke_abort) begin
          next_cur.st = CWC_BRAKE;
          next_cur.pass = 1'b0;
        end else if (!far_pos_sense_n_i) begin
          next_cur.st = CWC_FWD; // R09
        end
      end
      CWC_FWD: begin
        if (!home_pos_sense_n_i) begin
          next_cur.st = CWC_BRAKE; // R14
        end else if (stroke_abort) begin
          next_cur.st = CWC_BRAKE;
          next_cur.pass = 1'b0;
        end
      end
      CWC_BRAKE: begin
        if (brake_done) begin
          next_cur.st = CWC_IDLE; // R14
          next_cur.pass = 1'b0;
        end
      end
      default: begin
        next_cur.st = CWC_IDLE;
        next_cur.pass = 1'b0;
      end
    endcase

    case (next_cur.st)
      CWC_REV: next_cur.drive = `CWC_DRV_REV; // R07
      CWC_FWD: next_cur.drive = `CWC_DRV_NORM; // R08
      CWC_BRAKE: next_cur.drive = `CWC_DRV_BRAKE; // R10
      default: next_cur.drive = `CWC_DRV_OFF; // R10
    endcase

    // ****************************************************************
    // Register bus
    // ****************************************************************
    next_cur.ack = acc;
    if (wr) begin
      case (wb_req_i.adr)
        `CWC_ADR_CTRL: begin
          if (wb_req_i.sel[0]) begin
            next_cur.enable = wb_req_i.dat[`CWC_CTRL_EN_BIT];
          end
        end
        `CWC_ADR_THRESH: begin
          if (wb_req_i.sel[0]) begin
            next_cur.thresh[7:0] = wb_req_i.dat[7:0];
          end
          if (wb_req_i.sel[1]) begin
            next_cur.thresh[15:8] = wb_req_i.dat[15:8];
          end
        end
        default: begin
        end
      endcase
    end
    if (acc) begin
      next_cur.rdata = 32'h0000_0000;
      case (wb_req_i.adr)
        `CWC_ADR_CTRL: next_cur.rdata[`CWC_CTRL_EN_BIT] = cur.enable;
        `CWC_ADR_THRESH: next_cur.rdata[15:0] = cur.thresh;
        `CWC_ADR_COUNT: next_cur.rdata[15:0] = cur.cnt;
        `CWC_ADR_STATUS: begin
          next_cur.rdata[`CWC_ST_BUSY_BIT] = cur.pass;
          next_cur.rdata[`CWC_ST_PEND_BIT] = cur.evt_pend;
          next_cur.rdata[`CWC_ST_PREQ_BIT] = page_req;
          next_cur.rdata[`CWC_ST_HOME_N_BIT] = home_pos_sense_n_i; // R11
          next_cur.rdata[`CWC_ST_FAR_N_BIT] = far_pos_sense_n_i; // R12
          next_cur.rdata[`CWC_ST_DRV_A_BIT] = cur.drive[1];
          next_cur.rdata[`CWC_ST_DRV_B_BIT] = cur.drive[0];
          next_cur.rdata[`CWC_ST_FAULT_BIT] = cur.fault;
          next_cur.rdata[`CWC_ST_MOVE_BIT] = (cur.st != CWC_IDLE);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur <= CWC_RST;
    end else begin
      cur <= next_cur;
    end
  end

  assign cleaner_drive_a_o = cur.drive[1];
  assign cleaner_drive_b_o = cur.drive[0];
  assign pass_busy_o = cur.pass;
  assign wb_rsp_o.ack = cur.ack;
  assign wb_rsp_o.dat = cur.rdata;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_r01;
    $fell(rst_i) |-> ##[1:2] (cur.drive == `CWC_DRV_REV);
  endproperty
  a_r01: assert property (p_r01) else $error("no pass after reset"); // R01

  property p_r02;
    ($fell(energy_save_i) && (cur.st == CWC_IDLE) && cur.enable &&
      !cur.fault) |-> ##[1:3] (cur.drive == `CWC_DRV_REV);
  endproperty
  a_r02: assert property (p_r02) else $error("no pass on wake"); // R02

  property p_r03;
    (cur.cover_q && !front_cover_open_i && (cur.st == CWC_IDLE) &&
      cur.enable && !cur.fault) |-> ##[1:3] (cur.drive == `CWC_DRV_REV);
  endproperty
  a_r03: assert property (p_r03) else $error("no pass on cover"); // R03

  property p_r04;
    ((cur.st == CWC_IDLE) && cur.enable && !cur.fault && page_req &&
      !job_active_i) |=> (cur.drive == `CWC_DRV_REV) && cur.pass;
  endproperty
  a_r04: assert property (p_r04) else $error("no pass at count"); // R04

  property p_r05;
    ((cur.st == CWC_IDLE) && job_active_i && !cur.evt_pend) |=>
      (cur.drive != `CWC_DRV_REV);
  endproperty
  a_r05: assert property (p_r05) else $error("pass during job"); // R05

  property p_r06;
    ((cur.st == CWC_IDLE) && home_pos_sense_n_i && !launch) |=>
      (cur.drive == `CWC_DRV_NORM) && !cur.pass;
  endproperty
  a_r06: assert property (p_r06) else $error("not homing"); // R06

  property p_r09;
    ((cur.st == CWC_REV) && !far_pos_sense_n_i && !stroke_done) |=>
      (cur.drive == `CWC_DRV_NORM) ##1 (cur.st == CWC_FWD);
  endproperty
  a_r09: assert property (p_r09) else $error("no turn at far end"); // R09

  property p_r13;
    ((cur.st == CWC_REV) && far_pos_sense_n_i && !stroke_done) |=>
      (cur.drive == `CWC_DRV_REV);
  endproperty
  a_r13: assert property (p_r13) else $error("reverse ended early"); // R13

  property p_r14;
    ((cur.st == CWC_FWD) && !home_pos_sense_n_i) |=>
      (cur.drive == `CWC_DRV_BRAKE) [*2];
  endproperty
  a_r14: assert property (p_r14) else $error("no brake at home"); // R14

  property p_r14_clr;
    ((cur.st == CWC_BRAKE) && brake_done && cur.pass && !page_printed_i)
      |=> (cur.cnt == 16'h0000) && (cur.drive == `CWC_DRV_OFF);
  endproperty
  a_r14_clr: assert property (p_r14_clr) else $error("count kept"); // R14

  // Reverse straight into brake only on a stroke timeout
  property p_r10;
    ((cur.drive == `CWC_DRV_BRAKE) && ($past(cur.drive) == `CWC_DRV_REV))
      |-> cur.fault;
  endproperty
  a_r10: assert property (p_r10) else $error("reverse into brake"); // R10

  c_pass: cover property ((cur.st == CWC_BRAKE) && brake_done && cur.pass);
  c_page: cover property (page_req && launch);
  c_defer: cover property (page_req && job_active_i && (cur.st == CWC_IDLE));
  c_cover: cover property (cover_close && (cur.st == CWC_IDLE));

endmodule

// file: logic/cwc_defines.svh
// Constants of the charger wire cleaner controller: offsets, fields,
// reset values, motor codes and timing.
// Assumes a 100 MHz clock and a 32-bit classic Wishbone register bus.
`ifndef CWC_DEFINES_SVH
`define CWC_DEFINES_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define CWC_ADR_CTRL 8'h00
`define CWC_ADR_THRESH 8'h04
`define CWC_ADR_COUNT 8'h08
`define CWC_ADR_STATUS 8'h0c

// ****************************************************************
// Field positions
// ****************************************************************
`define CWC_CTRL_EN_BIT 0
`define CWC_CTRL_START_BIT 1
`define CWC_CTRL_FCLR_BIT 2
`define CWC_ST_BUSY_BIT 0
`define CWC_ST_PEND_BIT 1
`define CWC_ST_PREQ_BIT 2
`define CWC_ST_HOME_N_BIT 3
`define CWC_ST_FAR_N_BIT 4
`define CWC_ST_DRV_A_BIT 5
`define CWC_ST_DRV_B_BIT 6
`define CWC_ST_FAULT_BIT 7
`define CWC_ST_MOVE_BIT 8

// ****************************************************************
// Reset values
// ****************************************************************
`define CWC_THRESH_RST 16'h03e8
`define CWC_EN_RST 1'b1

// ****************************************************************
// Motor codes {drive_a, drive_b}
// ****************************************************************
`define CWC_DRV_OFF 2'b00
`define CWC_DRV_REV 2'b01
`define CWC_DRV_NORM 2'b10
`define CWC_DRV_BRAKE 2'b11

// ****************************************************************
// Timing
// ****************************************************************
`define CWC_CLK_MHZ 100
`define CWC_BRAKE_TIME_MS 50
`define CWC_BRAKE_CYCLES (`CWC_BRAKE_TIME_MS * `CWC_CLK_MHZ * 1000)
`define CWC_STROKE_TIME_MS 10000
`define CWC_STROKE_CYCLES (`CWC_STROKE_TIME_MS * `CWC_CLK_MHZ * 1000)
`define CWC_BRAKE_W 24
`define CWC_STROKE_W 30

`endif

// file: logic/cwc_down_timer.sv
// Loadable down counter with a level done flag.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps

module cwc_down_timer #(
  parameter int W = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [W-1:0] load_val_i,
  output logic done_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } cwc_tmr_s;

  cwc_tmr_s cur;
  cwc_tmr_s next_cur;

  always_comb begin
    next_cur = cur;
    if (load_i) begin
      next_cur.cnt = load_val_i;
    end else if (cur.cnt != '0) begin
      next_cur.cnt = cur.cnt - W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign done_o = (cur.cnt == '0);

endmodule

// file: logic/cwc_pkg.sv
// Types shared by the charger wire cleaner controller.
// Assumes cwc_defines.svh is visible for widths.
`include "cwc_defines.svh"

package cwc_pkg;

  typedef enum logic [1:0] {
    CWC_IDLE,
    CWC_REV,
    CWC_FWD,
    CWC_BRAKE
  } cwc_state_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } cwc_wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } cwc_wb_rsp_s;

  typedef struct packed {
    cwc_state_e st;
    logic pass;
    logic fault;
    logic evt_pend;
    logic energy_q;
    logic cover_q;
    logic enable;
    logic ack;
    logic [31:0] rdata;
    logic [15:0] cnt;
    logic [15:0] thresh;
    logic [1:0] drive;
  } cwc_ctrl_state_s;

endpackage

// file: verification/cwc_motor_model.sv
// Model of the cleaner motor, carriage and the two limit switches.
// Assumes drive lines change just after the rising clock edge.
`timescale 1ns/1ps
`include "cwc_defines.svh"

module cwc_motor_model #(
  parameter int LEN = 30,
  parameter int STEP = 1
) (
  input wire logic clk_i,
  input wire logic drive_a_i,
  input wire logic drive_b_i,
  output logic home_n_o,
  output logic far_n_o
);
  int pos = 0;
  int tick = 0;

  // ****************************************************************
  // Carriage travel
  // ****************************************************************
  // STEP above one gives a slow motor; brake and off both hold still
  always @(posedge clk_i) begin
    tick <= (tick + 1) % STEP;
    if (tick == STEP - 1) begin
      case ({drive_a_i, drive_b_i})
        `CWC_DRV_REV: if (pos < LEN) pos <= pos + 1;
        `CWC_DRV_NORM: if (pos > 0) pos <= pos - 1;
        default: pos <= pos;
      endcase
    end
  end

  assign home_n_o = (pos != 0);
  assign far_n_o = (pos != LEN);
endmodule

// file: verification/test_charger_wire_cleaner_ctrl.sv
// Self-checking bench of the charger wire cleaner controller.
// Assumes the motor model beside it and a short brake parameter.
`timescale 1ns/1ps
`include "cwc_defines.svh"

module test_charger_wire_cleaner_ctrl
  import cwc_pkg::*;
();
  localparam int BRK = 8;
  logic clk_i = 0;
  logic rst_i = 1;
  logic energy_i = 0;
  logic cover_i = 0;
  logic page_i = 0;
  logic job_i = 0;
  cwc_wb_req_s req = '0;
  cwc_wb_rsp_s rsp;
  logic home_n, far_n, drv_a, drv_b, busy;
  logic [1:0] drv;
  logic [31:0] rd;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;

  assign drv = {drv_a, drv_b};

  cwc_ctrl #(.BRAKE_CYCLES(24'(BRK)), .STROKE_CYCLES(30'h0000_07d0)) DUT (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_req_i(req),
    .wb_rsp_o(rsp),
    .energy_save_i(energy_i),
    .front_cover_open_i(cover_i),
    .page_printed_i(page_i),
    .job_active_i(job_i),
    .home_pos_sense_n_i(home_n),
    .far_pos_sense_n_i(far_n),
    .cleaner_drive_a_o(drv_a),
    .cleaner_drive_b_o(drv_b),
    .pass_busy_o(busy)
  );

  cwc_motor_model #(.LEN(30), .STEP(2)) motor (
    .clk_i(clk_i),
    .drive_a_i(drv_a),
    .drive_b_i(drv_b),
    .home_n_o(home_n),
    .far_n_o(far_n)
  );

  // ****************************************************************
  // Clock, timeout and shared tasks
  // ****************************************************************
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude;
    end
  end

  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task check(input string name, input logic [15:0] seen,
             input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, we, adr, 4'hf, wd};
    // Only the bench timeout ends this wait
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1);
    rd = rsp.dat;
    req <= '0;
    check("wb_lat", 16'(n), 16'h0002);
  endtask

  task pulse_page;
    @(posedge clk_i);
    page_i <= 1'b1;
    @(posedge clk_i);
    page_i <= 1'b0;
  endtask

  // Follows one whole pass and judges every step of it
  task run_pass(input int lim);
    int n;
    n = 0;
    while (drv !== `CWC_DRV_REV && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    check("launch_rev", 16'(drv), 16'(`CWC_DRV_REV));
    check("pass_busy", 16'(busy), 16'h0001);
    n = 0;
    while (far_n !== 1'b0 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    @(negedge clk_i);
    check("far_turn", 16'(drv), 16'(`CWC_DRV_NORM));
    n = 0;
    while (home_n !== 1'b0 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    @(negedge clk_i);
    check("home_brake", 16'(drv), 16'(`CWC_DRV_BRAKE));
    n = 0;
    while (drv === `CWC_DRV_BRAKE && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    check("brake_len", 16'(n), 16'(BRK + 1));
    check("idle_off", 16'(drv), 16'(`CWC_DRV_OFF));
    check("idle_busy", 16'(busy), 16'h0000);
    check("idle_home", 16'(home_n), 16'h0000);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_regs;
    wb(1'b0, `CWC_ADR_THRESH, 32'h0000_0000);
    check("thresh_rst", rd[15:0], 16'h03e8);
    wb(1'b1, 8'h10, 32'h0000_ffff);
    wb(1'b0, 8'h10, 32'h0000_0000);
    check("unmapped", rd[15:0], 16'h0000);
    $display("test regs done");
  endtask

  task t_energy;
    @(posedge clk_i);
    energy_i <= 1'b1;
    repeat (6) @(negedge clk_i);
    check("save_idle", 16'(drv), 16'(`CWC_DRV_OFF));
    @(posedge clk_i);
    energy_i <= 1'b0;
    run_pass(4);
    $display("test energy done");
  endtask

  task t_cover;
    @(posedge clk_i);
    cover_i <= 1'b1;
    repeat (6) @(negedge clk_i);
    check("open_idle", 16'(drv), 16'(`CWC_DRV_OFF));
    @(posedge clk_i);
    cover_i <= 1'b0;
    run_pass(4);
    $display("test cover done");
  endtask

  // Threshold boundary, then the last page lands inside a job
  task t_pages;
    wb(1'b1, `CWC_ADR_THRESH, 32'h0000_0003);
    repeat (2) pulse_page;
    repeat (6) @(negedge clk_i);
    check("below_thr", 16'(drv), 16'(`CWC_DRV_OFF));
    @(posedge clk_i);
    job_i <= 1'b1;
    pulse_page;
    repeat (20) @(negedge clk_i);
    check("deferred", 16'(drv), 16'(`CWC_DRV_OFF));
    wb(1'b0, `CWC_ADR_COUNT, 32'h0000_0000);
    check("count_thr", rd[15:0], 16'h0003);
    @(posedge clk_i);
    job_i <= 1'b0;
    run_pass(5);
    wb(1'b0, `CWC_ADR_COUNT, 32'h0000_0000);
    check("count_clr", rd[15:0], 16'h0000);
    $display("test pages done");
  endtask

  // Start request held back while disabled, then released
  task t_ctrl;
    wb(1'b1, `CWC_ADR_CTRL, 32'h0000_0002);
    repeat (6) @(negedge clk_i);
    check("disabled", 16'(drv), 16'(`CWC_DRV_OFF));
    wb(1'b0, `CWC_ADR_STATUS, 32'h0000_0000);
    check("status", rd[15:0], 16'h0012);
    wb(1'b1, `CWC_ADR_CTRL, 32'h0000_0001);
    run_pass(4);
    wb(1'b0, `CWC_ADR_CTRL, 32'h0000_0000);
    check("ctrl_en", rd[15:0], 16'h0001);
    $display("test ctrl done");
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    run_pass(4);
    $display("test power_on done");
    t_regs;
    t_energy;
    t_cover;
    t_pages;
    t_ctrl;
    conclude;
  end
endmodule
